// file: core/tdc_defs.svh
`ifndef TDC_DEFS_SVH
`define TDC_DEFS_SVH
// register byte offsets
`define TDC_OFF_CTRL      8'h00
`define TDC_OFF_STATUS    8'h04
`define TDC_OFF_MASK      8'h08
`define TDC_OFF_PENDING   8'h0C
`define TDC_OFF_INSTR     8'h10
`define TDC_OFF_VECTOR    8'h14
`define TDC_OFF_CPUREG    8'h18
`define TDC_OFF_SHADOW    8'h1C
`define TDC_OFF_STACK     8'h20
// ctrl fields
`define TDC_CTRL_GDIS     0
`define TDC_CTRL_HOLDHALT 1
`define TDC_CTRL_ONCHIP   2
`define TDC_CTRL_PIPEBUSY 3
`define TDC_CTRL_RPT      4
`define TDC_CTRL_WAIT     5
`define TDC_CTRL_VECTOR_PAGE_POINTER_LO  8
// instruction codes written to the instr register
`define TDC_OP_NONE       4'h0
`define TDC_OP_SWVEC      4'h1
`define TDC_OP_NMI        4'h2
`define TDC_OP_TRAP       4'h3
`define TDC_OP_IRQ_RETURN_ENABLE       4'h4
`define TDC_OP_IRQ_RETURN_KEEP_DISABLED       4'h5
`define TDC_OP_RET        4'h6
`define TDC_OP_CLRI       4'h7
`define TDC_OP_SETI       4'h8
`define TDC_OP_SST0       4'h9
`define TDC_OP_CALL       4'hA
// vectors and timing
`define TDC_VEC_TRAP      6'h22
`define TDC_VEC_NMI       6'h24
`define TDC_SYNC_CYC      3
`define TDC_RECOG_CYC     1
`define TDC_FLUSH_CYC     4
`define TDC_STACK_DEPTH   8
`define TDC_NUM_IRQ       16
`define TDC_NUM_KEYREG    11
`define TDC_RST_CTRL      32'h0000_0003
`endif

// file: core/tdc_pkg.sv
`default_nettype none
package tdc_pkg;
	typedef enum logic [1:0] {TDC_IDLE, TDC_JAM, TDC_FLUSH, TDC_ACK} tdc_state_type;
	typedef struct packed {
		logic [5:0]  vec;
		logic        save_ctx;
		logic        is_ext;
	} tdc_trap_type;
endpackage
`default_nettype wire

// file: core/tdc_trap_dispatch.sv
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tdc_defs.svh"
module tdc_trap_dispatch
	import tdc_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// pins
	input  wire logic        hard_restart_in,
	input  wire logic        nmi_pin_n,
	input  wire logic [15:0] irq_pins,
	input  wire logic [15:0] serial_active,
	input  wire logic        bus_hold_grant,
	output logic             irq_ack_out,
	output logic [4:0]       ack_addr,
	output logic [15:0]      pc_out,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	logic [31:0]       ctrl;
	logic [15:0]       irq_mask_reg;
	logic [15:0]       irq_pending_reg;
	logic [15:0]       cpu_regs [`TDC_NUM_KEYREG];
	logic [15:0]       shadow_regs [`TDC_NUM_KEYREG];
	logic [15:0]       ret_stack [`TDC_STACK_DEPTH];
	logic [3:0]        sp;
	logic [15:0]       sst_value;
	logic [3:0]        reg_sel;
	logic [15:0]       s1;
	logic [15:0]       s2;
	logic [15:0]       s3;
	logic [15:0]       pin_prev;
	logic              n1;
	logic              n2;
	logic              n3;
	logic              nmi_prev;
	logic              nmi_req;
	logic              hr1;
	logic              hr2;
	logic              hb1;
	logic              hb2;
	logic [1:0]        shield;
	tdc_state_type     state;
	logic [2:0]        cnt;
	tdc_trap_type      cur;
	logic [4:0]        cur_num;
	logic              aw_got;
	logic              w_got;
	logic [7:0]        aw_addr;
	logic [31:0]       w_data;
	logic              wr_fire;
	logic [3:0]        op;
	logic [4:0]        op_arg;
	logic              gdis;
	logic              blocked;
	logic              hold_blocks;
	logic              pick_ok;
	logic [3:0]        pick_num;
	logic [15:0]       enabled;

	assign gdis = ctrl[`TDC_CTRL_GDIS];
	assign wr_fire = aw_got && w_got && !s_axi_bvalid;
	assign op = (wr_fire && aw_addr == `TDC_OFF_INSTR) ? w_data[3:0] : `TDC_OP_NONE;
	assign op_arg = w_data[8:4];
	assign hold_blocks = hb2
		&& !(!ctrl[`TDC_CTRL_HOLDHALT] && ctrl[`TDC_CTRL_ONCHIP]);
	assign blocked = ctrl[`TDC_CTRL_PIPEBUSY] || ctrl[`TDC_CTRL_RPT]
		|| hold_blocks || shield != 2'd0 || state != TDC_IDLE;
	assign enabled = irq_pending_reg & irq_mask_reg & {16{!gdis}};

	always_comb
	begin
		pick_ok = 1'b0;
		pick_num = 4'h0;
		for (int i = `TDC_NUM_IRQ - 1; i >= 0; i--)
		begin
			if (enabled[i])
			begin
				pick_ok = 1'b1;
				pick_num = 4'(i);
			end
		end
	end

	// input synchronisers; third stage gives the 3-cycle sync of the latency budget
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s1 <= 16'h0000;
			s2 <= 16'h0000;
			s3 <= 16'h0000;
			n1 <= 1'b1;
			n2 <= 1'b1;
			n3 <= 1'b1;
			hr1 <= 1'b1;
			hr2 <= 1'b1;
			hb1 <= 1'b0;
			hb2 <= 1'b0;
		end
		else
		begin
			s1 <= irq_pins;
			s2 <= s1;
			s3 <= s2;
			n1 <= nmi_pin_n;
			n2 <= n1;
			n3 <= n2;
			hr1 <= hard_restart_in;
			hr2 <= hr1;
			hb1 <= bus_hold_grant;
			hb2 <= hb1;
		end
	end

	// pending flags: set wins over clear; number n owns flag n-1
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !hr2)
		begin
			irq_pending_reg <= 16'h0000;
			pin_prev <= 16'h0000;
		end
		else
		begin
			pin_prev <= s3;
			irq_pending_reg <= (irq_pending_reg
				& ~((wr_fire && aw_addr == `TDC_OFF_PENDING) ? w_data[15:0] : 16'h0000)
				& ~((state == TDC_ACK && cur.is_ext)
					? (16'h0001 << (cur_num - 5'd1)) & ~serial_active : 16'h0000))
				| (s3 & ~pin_prev);
		end
	end

	// soft-reset request latch, held until dispatch
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !hr2)
		begin
			nmi_req <= 1'b0;
			nmi_prev <= 1'b1;
		end
		else
		begin
			nmi_prev <= n3;
			if (!n3 && nmi_prev)
				nmi_req <= 1'b1;
			else if (state == TDC_IDLE && !blocked && nmi_req)
				nmi_req <= 1'b0;
		end
	end

	// dispatch sequencer
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !hr2)
		begin
			state <= TDC_IDLE;
			cnt <= 3'd0;
			cur <= '0;
			cur_num <= 5'd0;
		end
		else
		begin
			unique case (state)
				TDC_IDLE:
				begin
					if (op == `TDC_OP_NMI || (nmi_req && !blocked))
					begin
						cur <= '{vec: `TDC_VEC_NMI, save_ctx: 1'b0, is_ext: 1'b0};
						cur_num <= 5'h12;
						state <= TDC_JAM;
					end
					else if (op == `TDC_OP_TRAP)
					begin
						cur <= '{vec: `TDC_VEC_TRAP, save_ctx: 1'b0, is_ext: 1'b0};
						cur_num <= 5'h11;
						state <= TDC_JAM;
					end
					else if (op == `TDC_OP_SWVEC)
					begin
						cur <= '{vec: {op_arg, 1'b0}, save_ctx: 1'b1, is_ext: 1'b1};
						cur_num <= op_arg;
						state <= TDC_JAM;
					end
					else if (pick_ok && !blocked)
					begin
						// five bits so that flag 15 reaches number 16, not vector 0
						cur <= '{vec: {5'({1'b0, pick_num} + 5'd1), 1'b0}, save_ctx: 1'b1,
							is_ext: 1'b1};
						cur_num <= 5'({1'b0, pick_num} + 5'd1);
						state <= TDC_JAM;
					end
				end
				TDC_JAM:
				begin
					cnt <= 3'(`TDC_FLUSH_CYC - 2);
					state <= TDC_FLUSH;
				end
				TDC_FLUSH:
				begin
					if (ctrl[`TDC_CTRL_PIPEBUSY] || ctrl[`TDC_CTRL_WAIT])
						cnt <= cnt;
					else if (cnt == 3'd0)
						state <= TDC_ACK;
					else
						cnt <= cnt - 3'd1;
				end
				TDC_ACK:
				begin
					if (!ctrl[`TDC_CTRL_WAIT])
						state <= TDC_IDLE;
				end
			endcase
		end
	end

	// ctrl register, global disable handling
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !hr2)
			ctrl <= `TDC_RST_CTRL;
		else
		begin
			if (wr_fire && aw_addr == `TDC_OFF_CTRL)
				ctrl <= w_data;
			if (op == `TDC_OP_SETI)
				ctrl[`TDC_CTRL_GDIS] <= 1'b1;
			if (op == `TDC_OP_CLRI || op == `TDC_OP_IRQ_RETURN_ENABLE)
				ctrl[`TDC_CTRL_GDIS] <= 1'b0;
			if (state == TDC_JAM)
				ctrl[`TDC_CTRL_GDIS] <= 1'b1;
		end
	end

	// one-instruction shield after disable set/clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			shield <= 2'd0;
		else if (op == `TDC_OP_SETI || op == `TDC_OP_CLRI)
			shield <= 2'd1;
		else if (shield != 2'd0 && op != `TDC_OP_NONE)
			shield <= shield - 2'd1;
	end

	// stack, key registers and shadows
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !hr2)
		begin
			sp <= 4'd0;
			pc_out <= 16'h0000;
			sst_value <= 16'h0000;
			reg_sel <= 4'd0;
			for (int i = 0; i < `TDC_NUM_KEYREG; i++)
			begin
				cpu_regs[i] <= 16'h0000;
				shadow_regs[i] <= 16'h0000;
			end
			for (int i = 0; i < `TDC_STACK_DEPTH; i++)
				ret_stack[i] <= 16'h0000;
		end
		else
		begin
			if (wr_fire && aw_addr == `TDC_OFF_CPUREG)
			begin
				reg_sel <= w_data[19:16];
				if (w_data[19:16] < 4'(`TDC_NUM_KEYREG))
					cpu_regs[w_data[19:16]] <= w_data[15:0];
			end
			if (op == `TDC_OP_SST0)
				// this store retires the last shield step, so a waiting trap follows it
				sst_value <= {cpu_regs[6][15:1],
					gdis || state == TDC_JAM || (state == TDC_IDLE && pick_ok
					&& shield < 2'd2 && !ctrl[`TDC_CTRL_PIPEBUSY] && !ctrl[`TDC_CTRL_RPT]
					&& !hold_blocks)};
			if (op == `TDC_OP_CALL && sp != 4'(`TDC_STACK_DEPTH))
			begin
				ret_stack[sp[2:0]] <= w_data[31:16];
				sp <= sp + 4'd1;
			end
			if (state == TDC_JAM)
			begin
				if (sp != 4'(`TDC_STACK_DEPTH))
				begin
					ret_stack[sp[2:0]] <= pc_out;
					sp <= sp + 4'd1;
				end
				if (cur.save_ctx)
					for (int i = 0; i < `TDC_NUM_KEYREG; i++)
						shadow_regs[i] <= cpu_regs[i];
			end
			if (state == TDC_ACK && !ctrl[`TDC_CTRL_WAIT])
				// 2K-word pages: pointer sits above the 11-bit offset
				pc_out <= {ctrl[`TDC_CTRL_VECTOR_PAGE_POINTER_LO +: 5], 5'b00000, cur.vec};
			if ((op == `TDC_OP_IRQ_RETURN_ENABLE || op == `TDC_OP_IRQ_RETURN_KEEP_DISABLED || op == `TDC_OP_RET) && sp != 4'd0)
			begin
				pc_out <= ret_stack[sp[2:0] - 3'd1];
				sp <= sp - 4'd1;
			end
			if (op == `TDC_OP_IRQ_RETURN_ENABLE || op == `TDC_OP_IRQ_RETURN_KEEP_DISABLED)
				for (int i = 0; i < `TDC_NUM_KEYREG; i++)
					cpu_regs[i] <= (i == 6) ? {shadow_regs[i][15:1], cpu_regs[i][0]}
						: (i == 7) ? {shadow_regs[i][15:14], cpu_regs[i][13], shadow_regs[i][12:0]}
						: shadow_regs[i];
		end
	end

	// acknowledge pulse with number on address bits
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_ack_out <= 1'b0;
			ack_addr <= 5'd0;
		end
		else
		begin
			irq_ack_out <= state == TDC_ACK && !ctrl[`TDC_CTRL_WAIT];
			if (state == TDC_ACK)
				ack_addr <= cur_num;
		end
	end

	// axi4-lite write channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr[1:0] != 2'b00 || aw_addr > `TDC_OFF_STACK) ? 2'b10 : 2'b00;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// axi4-lite read channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			unique case (s_axi_araddr)
				`TDC_OFF_CTRL:    s_axi_rdata <= ctrl;
				`TDC_OFF_STATUS:  s_axi_rdata <= {16'h0000, sst_value};
				`TDC_OFF_MASK:    s_axi_rdata <= {16'h0000, irq_mask_reg};
				`TDC_OFF_PENDING: s_axi_rdata <= {16'h0000, irq_pending_reg};
				`TDC_OFF_INSTR:   s_axi_rdata <= {22'h0, state, sp, shield, nmi_req, 1'b0};
				`TDC_OFF_VECTOR:  s_axi_rdata <= {16'h0000, pc_out};
				`TDC_OFF_CPUREG:  s_axi_rdata <= {12'h000, reg_sel,
					reg_sel < 4'(`TDC_NUM_KEYREG) ? cpu_regs[reg_sel] : 16'h0000};
				`TDC_OFF_SHADOW:  s_axi_rdata <= {12'h000, reg_sel,
					reg_sel < 4'(`TDC_NUM_KEYREG) ? shadow_regs[reg_sel] : 16'h0000};
				`TDC_OFF_STACK:   s_axi_rdata <= {16'h0000,
					sp != 4'd0 ? ret_stack[sp[2:0] - 3'd1] : 16'h0000};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'b10;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// mask register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_mask_reg <= 16'h0000;
		else if (wr_fire && aw_addr == `TDC_OFF_MASK)
			irq_mask_reg <= w_data[15:0];
	end

	sequence s_jam;
		state == TDC_JAM;
	endsequence
	sequence s_ack_seen;
		##[3:60] irq_ack_out;
	endsequence

	a_jam_sets_disable: assert property (@(posedge aclk) disable iff (!aresetn || !hr2)
		s_jam |=> gdis) else $error("disable not set after jam");
	a_jam_then_ack: assert property (@(posedge aclk) disable iff (!aresetn || !hr2)
		s_jam |-> s_ack_seen) else $error("no ack after jam");
	a_nmi_no_save: assert property (@(posedge aclk) disable iff (!aresetn || !hr2)
		(s_jam and !cur.save_ctx) |=> $stable(shadow_regs[0])) else $error("soft trap saved");
	a_trap_vec22: assert property (@(posedge aclk) disable iff (!aresetn || !hr2)
		state == TDC_IDLE && op == `TDC_OP_TRAP && !nmi_req |=> cur.vec == 6'h22)
		else $error("trap vector wrong");
	a_shield_holds: assert property (@(posedge aclk) disable iff (!aresetn || !hr2)
		shield != 2'd0 && op != `TDC_OP_NMI && op != `TDC_OP_TRAP && op != `TDC_OP_SWVEC
		|=> state != TDC_JAM) else $error("trap inside shield");
	a_rpt_defers: assert property (@(posedge aclk) disable iff (!aresetn || !hr2)
		ctrl[`TDC_CTRL_RPT] && state == TDC_IDLE && op == `TDC_OP_NONE |=> state == TDC_IDLE)
		else $error("trap during repeat");
	a_stack_push: assert property (@(posedge aclk) disable iff (!aresetn || !hr2)
		(s_jam and (sp < 4'd8 && op == `TDC_OP_NONE)) |=> sp == $past(sp) + 4'd1)
		else $error("pc not pushed");
	a_hold_blocks: assert property (@(posedge aclk) disable iff (!aresetn || !hr2)
		hold_blocks && state == TDC_IDLE && op == `TDC_OP_NONE |=> state == TDC_IDLE)
		else $error("trap during hold");
endmodule
`default_nettype wire

// file: sim/tdc_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module tdc_far_side
(
	// clock
	input  wire logic        aclk,
	// requests from the bench
	input  wire logic [15:0] irq_req,
	input  wire logic        nmi_req,
	input  wire logic        hold_req,
	// pins toward the block
	output logic [15:0]      irq_pins,
	output logic             nmi_pin_n,
	output logic             bus_hold_grant
);
	// pins lag the request by one cycle, like a board signal
	always_ff @(posedge aclk)
	begin
		irq_pins  <= irq_req;
		nmi_pin_n <= ~nmi_req;
	end

	// grant stands for the whole request, never dropped early
	always_ff @(posedge aclk)
		bus_hold_grant <= hold_req;
endmodule
`default_nettype wire

// file: sim/tdc_trap_dispatch_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tdc_defs.svh"
module tdc_trap_dispatch_tb;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        hard_restart_in = 1'b1;
	logic [15:0] irq_req = 16'h0000;
	logic        nmi_req = 1'b0;
	logic        hold_req = 1'b0;
	logic [15:0] serial_active = 16'h0000;
	logic [15:0] irq_pins;
	logic        nmi_pin_n;
	logic        bus_hold_grant;
	logic        irq_ack_out;
	logic [4:0]  ack_addr;
	logic [15:0] pc_out;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready;
	logic        s_axi_wready;
	logic        s_axi_bvalid;
	logic        s_axi_arready;
	logic        s_axi_rvalid;
	logic [1:0]  s_axi_bresp;
	logic [1:0]  s_axi_rresp;
	logic [31:0] s_axi_rdata;
	int          miscompares = 0;
	int          n_tests = 0;

	always #25 aclk = ~aclk;

	tdc_far_side i_tdc_far_side (.aclk, .irq_req, .nmi_req, .hold_req, .irq_pins, .nmi_pin_n,
		.bus_hold_grant);

	tdc_trap_dispatch i_tdc_trap_dispatch (.aclk, .aresetn, .hard_restart_in, .nmi_pin_n,
		.irq_pins, .serial_active, .bus_hold_grant, .irq_ack_out, .ack_addr, .pc_out,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);

	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t ns: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1)
			begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready === 1'b1)
			begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1)
			@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
			@(posedge aclk);
		while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1)
			@(posedge aclk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(d, exp, what);
	endtask

	task automatic wait_pc(input logic [15:0] v, input string what);
		int i;
		for (i = 0; i < 60 && pc_out !== v; i++)
			@(posedge aclk);
		chk({16'h0000, pc_out}, {16'h0000, v}, what);
	endtask

	task automatic wait_ack(output int n);
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (irq_ack_out !== 1'b1 && n < 60);
	endtask

	task automatic no_ack(input int cyc, input string what);
		int k;
		k = 0;
		repeat (cyc)
		begin
			@(posedge aclk);
			if (irq_ack_out !== 1'b0)
				k++;
		end
		chk(k, 0, what);
	endtask

	task automatic t_reset;
		logic [31:0] d;
		logic [1:0]  r;
		rdchk(`TDC_OFF_CTRL, `TDC_RST_CTRL, "ctrl at reset");
		wr(`TDC_OFF_CTRL, 32'h0000_0000);
		hard_restart_in <= 1'b0;
		repeat (4) @(posedge aclk);
		hard_restart_in <= 1'b1;
		repeat (4) @(posedge aclk);
		rdchk(`TDC_OFF_CTRL, `TDC_RST_CTRL, "ctrl after restart");
		chk({16'h0000, pc_out}, 32'h0, "pc after restart");
		rd(8'h40, d, r);
		chk({30'h0, r}, 32'h2, "unmapped resp");
		chk(d, 32'h0, "unmapped data");
		$display("test reset done");
	endtask

	task automatic t_ctx;
		logic [31:0] v0;
		logic [31:0] v1;
		logic [31:0] s0;
		logic [1:0]  r;
		wr(`TDC_OFF_CTRL, 32'h0000_0000);
		wr(`TDC_OFF_CPUREG, 32'h0000_A5A5);
		rd(`TDC_OFF_CPUREG, v0, r);
		wr(`TDC_OFF_INSTR, 32'h0000_0051);
		wait_pc(16'h000A, "sw vector");
		rdchk(`TDC_OFF_CPUREG, v0, "live reg kept");
		rdchk(`TDC_OFF_STACK, 32'h0, "stack top");
		rd(`TDC_OFF_SHADOW, s0, r);
		wr(`TDC_OFF_CPUREG, 32'h0000_1111);
		rd(`TDC_OFF_CPUREG, v1, r);
		wr(`TDC_OFF_INSTR, `TDC_OP_NMI);
		wait_pc(16'h0024, "soft reset instr");
		rdchk(`TDC_OFF_SHADOW, s0, "shadow kept");
		rdchk(`TDC_OFF_STACK, 32'h000A, "stack top");
		wr(`TDC_OFF_INSTR, `TDC_OP_RET);
		wait_pc(16'h000A, "plain return");
		rdchk(`TDC_OFF_CPUREG, v1, "plain return kept live");
		wr(`TDC_OFF_INSTR, `TDC_OP_IRQ_RETURN_KEEP_DISABLED);
		wait_pc(16'h0000, "keep-disabled return");
		rdchk(`TDC_OFF_CPUREG, v0, "shadow restored");
		rdchk(`TDC_OFF_CTRL, 32'h1, "disable kept");
		wr(`TDC_OFF_INSTR, `TDC_OP_TRAP);
		wait_pc(16'h0022, "trap");
		wr(`TDC_OFF_INSTR, `TDC_OP_RET);
		wait_pc(16'h0000, "trap return");
		$display("test context done");
	endtask

	task automatic t_ext;
		int n;
		wr(`TDC_OFF_MASK, 32'h0000_0003);
		for (int c = 0; c < 2; c++)
		begin
			wr(`TDC_OFF_CTRL, 32'(c) << 8);
			irq_req <= 16'h0001 << c;
			wait_ack(n);
			chk(32'(n >= 9 && n < 60), 32'h1, "ack latency");
			chk({27'h0, ack_addr}, 32'(c + 1), "ack number");
			irq_req <= 16'h0000;
			wait_pc(c ? 16'h0804 : 16'h0002, "vector");
			rdchk(`TDC_OFF_PENDING, 32'h0, "pending cleared");
			rdchk(`TDC_OFF_CTRL, (32'(c) << 8) | 32'h1, "disable set");
			wr(`TDC_OFF_INSTR, `TDC_OP_IRQ_RETURN_ENABLE);
			wait_pc(16'h0000, "enabling return");
			rdchk(`TDC_OFF_CTRL, 32'(c) << 8, "disable cleared");
		end
		$display("test external done");
	endtask

	task automatic t_hold;
		int n;
		for (int c = 0; c < 2; c++)
		begin
			wr(`TDC_OFF_CTRL, c ? 32'h0000_0004 : 32'h0000_0002);
			hold_req <= 1'b1;
			repeat (3) @(posedge aclk);
			irq_req <= 16'h0001;
			if (c == 0)
			begin
				no_ack(30, "trap during hold");
				hold_req <= 1'b0;
			end
			wait_ack(n);
			chk(32'(n < 60), 32'h1, "trap after hold");
			hold_req <= 1'b0;
			irq_req <= 16'h0000;
			wr(`TDC_OFF_INSTR, `TDC_OP_IRQ_RETURN_ENABLE);
			wait_pc(16'h0000, "hold return");
		end
		$display("test hold done");
	endtask

	task automatic t_defer;
		wr(`TDC_OFF_CTRL, 32'h0000_0001);
		irq_req <= 16'h0001;
		no_ack(30, "trap while disabled");
		irq_req <= 16'h0000;
		rdchk(`TDC_OFF_PENDING, 32'h1, "pending kept");
		wr(`TDC_OFF_CTRL, 32'h0000_0011);
		nmi_req <= 1'b1;
		repeat (30) @(posedge aclk);
		chk({16'h0000, pc_out}, 32'h0, "soft reset in repeat");
		wr(`TDC_OFF_CTRL, 32'h0000_0001);
		wait_pc(16'h0024, "soft reset pin");
		nmi_req <= 1'b0;
		wr(`TDC_OFF_PENDING, 32'h0000_0001);
		rdchk(`TDC_OFF_PENDING, 32'h0, "pending write clear");
		wr(`TDC_OFF_INSTR, `TDC_OP_IRQ_RETURN_KEEP_DISABLED);
		wait_pc(16'h0000, "soft reset return");
		$display("test defer done");
	endtask

	task automatic t_shield;
		int n;
		wr(`TDC_OFF_CPUREG, 32'h0006_8000);
		wr(`TDC_OFF_INSTR, `TDC_OP_CLRI);
		rdchk(`TDC_OFF_CTRL, 32'h0, "clear disable");
		irq_req <= 16'h0001;
		no_ack(30, "trap inside shield");
		wr(`TDC_OFF_INSTR, `TDC_OP_SST0);
		wait_ack(n);
		chk(32'(n < 60), 32'h1, "trap after shield");
		irq_req <= 16'h0000;
		rdchk(`TDC_OFF_STATUS, 32'h0000_8001, "store ahead of trap");
		wr(`TDC_OFF_INSTR, `TDC_OP_IRQ_RETURN_ENABLE);
		wait_pc(16'h0000, "shield return");
		wr(`TDC_OFF_CTRL, 32'h0000_0020);
		wr(`TDC_OFF_INSTR, `TDC_OP_TRAP);
		no_ack(20, "ack during wait state");
		wr(`TDC_OFF_CTRL, 32'h0000_0001);
		wait_pc(16'h0022, "trap after wait state");
		wr(`TDC_OFF_INSTR, `TDC_OP_IRQ_RETURN_ENABLE);
		wait_pc(16'h0000, "wait trap return");
		wr(`TDC_OFF_INSTR, `TDC_OP_SETI);
		rdchk(`TDC_OFF_CTRL, 32'h1, "set disable");
		wr(`TDC_OFF_INSTR, 32'h1234_000A);
		rdchk(`TDC_OFF_STACK, 32'h1234, "call pushed");
		wr(`TDC_OFF_INSTR, `TDC_OP_RET);
		wait_pc(16'h1234, "call return");
		$display("test shield done");
	endtask

	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_ctx();
		t_ext();
		t_hold();
		t_defer();
		t_shield();
		wrap_up();
	end

	// whole run is a few hundred cycles
	initial
	begin
		repeat (20000) @(posedge aclk);
		$display("wrong value at %0t ns: watchdog expired", $time);
		miscompares++;
		wrap_up();
	end
endmodule
`default_nettype wire
